// ### logic/sau_pkg.sv
/*
 * Package of the saturating arithmetic unit: operation codes,
 * condition codes, field positions and reset values.
 * Assumes a single 25 MHz core clock and an active-low async reset.
 */
`default_nettype none
package sau_pkg;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        SAU_OP_NONE,
        SAU_OP_SIGNED_DUAL_HALF_CLAMP,
        SAU_OP_UNSIGNED_DUAL_HALF_CLAMP,
        SAU_OP_SIGNED_SAT_ADD_WORD,
        SAU_OP_SIGNED_SAT_SUB_WORD,
        SAU_OP_SIGNED_SAT_ADD_HALVES,
        SAU_OP_SIGNED_SAT_SUB_HALVES,
        SAU_OP_SIGNED_SAT_ADD_BYTES,
        SAU_OP_SIGNED_SAT_SUB_BYTES,
        SAU_OP_SIGNED_ADD_SUB_EXCHANGE,
        SAU_OP_SIGNED_SUB_ADD_EXCHANGE,
        SAU_OP_SAT_DOUBLE_AND_ADD,
        SAU_OP_SAT_DOUBLE_AND_SUB,
        SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE,
        SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE
    } sau_op_t;

    // ------------------------------------------------------------
    // Condition codes and status word fields
    // ------------------------------------------------------------
    localparam logic [3:0] SAU_COND_EQ = 4'h0;
    localparam logic [3:0] SAU_COND_NE = 4'h1;
    localparam logic [3:0] SAU_COND_CS = 4'h2;
    localparam logic [3:0] SAU_COND_CC = 4'h3;
    localparam logic [3:0] SAU_COND_MI = 4'h4;
    localparam logic [3:0] SAU_COND_PL = 4'h5;
    localparam logic [3:0] SAU_COND_VS = 4'h6;
    localparam logic [3:0] SAU_COND_VC = 4'h7;
    localparam logic [3:0] SAU_COND_HI = 4'h8;
    localparam logic [3:0] SAU_COND_LS = 4'h9;
    localparam logic [3:0] SAU_COND_GE = 4'hA;
    localparam logic [3:0] SAU_COND_LT = 4'hB;
    localparam logic [3:0] SAU_COND_GT = 4'hC;
    localparam logic [3:0] SAU_COND_LE = 4'hD;
    localparam logic [3:0] SAU_COND_AL = 4'hE;

    localparam int SAU_FLAG_N_POS = 31;
    localparam int SAU_FLAG_Z_POS = 30;
    localparam int SAU_FLAG_C_POS = 29;
    localparam int SAU_FLAG_V_POS = 28;
    localparam int SAU_FLAG_Q_POS = 27;

    localparam logic        SAU_Q_RESET      = 1'b0;
    localparam logic [31:0] SAU_RESULT_RESET = 32'h0000_0000;

    // Bit position limits of the dual-halfword clamps
    localparam logic [4:0] SAU_SCLAMP_MIN = 5'h01;
    localparam logic [4:0] SAU_SCLAMP_MAX = 5'h10;
    localparam logic [4:0] SAU_UCLAMP_MAX = 5'h0F;

endpackage
`default_nettype wire

// ### logic/sau_cond_check.sv
/*
 * Condition evaluator: decides from the four condition flags whether
 * a conditional operation executes.
 * Assumes flags are supplied by the core's status register.
 */
`timescale 1ns/1ps
`default_nettype none
module sau_cond_check
(
    input  wire logic [3:0] cond,     // Condition field
    input  wire logic [3:0] nzcv,     // N, Z, C, V flags
    output logic            pass      // Condition holds
);
    wire n = nzcv[3];
    wire z = nzcv[2];
    wire c = nzcv[1];
    wire v = nzcv[0];

    always_comb
    begin
        unique case (cond)
            sau_pkg::SAU_COND_EQ: pass = z;
            sau_pkg::SAU_COND_NE: pass = !z;
            sau_pkg::SAU_COND_CS: pass = c;
            sau_pkg::SAU_COND_CC: pass = !c;
            sau_pkg::SAU_COND_MI: pass = n;
            sau_pkg::SAU_COND_PL: pass = !n;
            sau_pkg::SAU_COND_VS: pass = v;
            sau_pkg::SAU_COND_VC: pass = !v;
            sau_pkg::SAU_COND_HI: pass = c && !z;
            sau_pkg::SAU_COND_LS: pass = !c || z;
            sau_pkg::SAU_COND_GE: pass = (n == v);
            sau_pkg::SAU_COND_LT: pass = (n != v);
            sau_pkg::SAU_COND_GT: pass = !z && (n == v);
            sau_pkg::SAU_COND_LE: pass = z || (n != v);
            default:              pass = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// ### logic/sau_core.sv
/*
 * Saturating arithmetic unit: one-cycle registered datapath for
 * dual-halfword clamps, signed lane add/sub, exchange forms and
 * double-and-add/sub, plus the sticky saturation flag.
 * Assumes the decoder never names SP or PC and holds op/operands
 * steady with op_valid for the issuing cycle only.
 */
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Dual-halfword clamp positions: signed 1..16, unsigned 0..15.
//- Signed dual clamp saturates each halfword lane independently.
//- Unsigned dual clamp treats halfwords as signed, clamps unsigned.
//- Any clamped dual-clamp lane sets the sticky flag.
//- N, Z, C, V flags are never modified here.
//- Signed sat add/sub on one word, two halves or four bytes.
//- Word signed add/sub sets sticky flag when clamped.
//- Byte and half lane add/sub never touch the sticky flag.
//- Sticky flag cleared only by move-to-status write.
//- Sticky flag readable via move-from-status.
//- Signed add-sub-exchange bottom: a.lo minus b.hi, saturated.
//- Signed add-sub-exchange top: a.hi plus b.lo, saturated.
//- Signed sub-add-exchange: bottom a.lo+b.hi, top a.hi-b.lo.
//- Double-and-add: saturate 2*b, then saturating add to a.
//- Double-and-sub: saturate 2*b, then saturating subtract from a.
//- Both stages clamp to 32-bit signed; either sets sticky flag.
//- Unsigned add-sub-exchange: top sum, bottom difference, saturated.
//- Unsigned sub-add-exchange: top a.hi-b.lo, bottom a.lo+b.hi.
//- Results and flag updates only when the condition passes.
//- Signed n-bit saturation clamps to -2^(n-1)..2^(n-1)-1.
//- Unsigned n-bit saturation clamps to 0..2^n-1.
module sau_core
(
    input  wire logic          clk,          // Core clock
    input  wire logic          nrst,         // Async reset, active low
    input  wire logic          op_valid,     // Operation issued
    input  wire sau_pkg::sau_op_t op,        // Operation select
    input  wire logic [3:0]    cond,         // Condition field
    input  wire logic [3:0]    nzcv_in,      // Current N,Z,C,V flags
    input  wire logic [4:0]    sat_pos,      // Clamp bit position
    input  wire logic [31:0]   first_operand_register,  // First operand
    input  wire logic [31:0]   second_operand_register, // Second operand
    input  wire logic          move_to_status_reg,      // Status write
    input  wire logic          q_wdata,      // Flag value written
    output logic               result_valid, // Result write strobe
    output logic [31:0]        result,       // Destination value
    output logic               q_flag,       // Sticky flag, readable
    output logic               sat_event     // A clamp set the sticky flag
);
    // ------------------------------------------------------------
    // Saturation helpers
    // ------------------------------------------------------------
    // Signed clamp of a 34-bit value to n bits; returns {sat, value}
    function automatic logic [32:0] sclamp(input logic signed [33:0] x,
                                           input logic [5:0] n);
        logic signed [33:0] hi;
        logic signed [33:0] lo;
        hi = (34'sh1 <<< (n - 6'h01)) - 34'sh1;
        lo = -(34'sh1 <<< (n - 6'h01));
        if (x > hi)
            sclamp = {1'b1, hi[31:0]};
        else if (x < lo)
            sclamp = {1'b1, lo[31:0]};
        else
            sclamp = {1'b0, x[31:0]};
    endfunction

    // Unsigned clamp of a signed 34-bit value to n bits
    function automatic logic [32:0] uclamp(input logic signed [33:0] x,
                                           input logic [5:0] n);
        logic signed [33:0] hi;
        hi = (34'sh1 <<< n) - 34'sh1;
        if (x < 34'sh0)
            uclamp = {1'b1, 32'h0000_0000};
        else if (x > hi)
            uclamp = {1'b1, hi[31:0]};
        else
            uclamp = {1'b0, x[31:0]};
    endfunction

    function automatic logic signed [33:0] sx16(input logic [15:0] h);
        sx16 = 34'(signed'(h));
    endfunction

    function automatic logic signed [33:0] zx16(input logic [15:0] h);
        zx16 = {18'h00000, h};
    endfunction

    function automatic logic signed [33:0] sx8(input logic [7:0] b);
        sx8 = 34'(signed'(b));
    endfunction

    // ------------------------------------------------------------
    // Operand lanes
    // ------------------------------------------------------------
    wire logic [31:0] a = first_operand_register;
    wire logic [31:0] b = second_operand_register;
    wire logic signed [33:0] a_w = 34'(signed'(a));
    wire logic signed [33:0] b_w = 34'(signed'(b));
    wire logic [5:0] pos6 = {1'b0, sat_pos};
    wire logic sub_sel = (op == sau_pkg::SAU_OP_SIGNED_SAT_SUB_WORD)
                      || (op == sau_pkg::SAU_OP_SIGNED_SAT_SUB_HALVES)
                      || (op == sau_pkg::SAU_OP_SIGNED_SAT_SUB_BYTES);

    // Dual-halfword clamps
    wire logic pos_ok_s = (sat_pos >= sau_pkg::SAU_SCLAMP_MIN)
                       && (sat_pos <= sau_pkg::SAU_SCLAMP_MAX);
    wire logic pos_ok_u = (sat_pos <= sau_pkg::SAU_UCLAMP_MAX);
    wire logic [32:0] sc_lo = sclamp(sx16(b[15:0]), pos6);
    wire logic [32:0] sc_hi = sclamp(sx16(b[31:16]), pos6);
    wire logic [32:0] uc_lo = uclamp(sx16(b[15:0]), pos6);
    wire logic [32:0] uc_hi = uclamp(sx16(b[31:16]), pos6);

    // Word add/sub
    wire logic [32:0] w_sum = sclamp(sub_sel ? a_w - b_w : a_w + b_w,
                                     6'd32);

    // Half lanes
    wire logic [32:0] h_lo = sclamp(sub_sel
        ? sx16(a[15:0]) - sx16(b[15:0])
        : sx16(a[15:0]) + sx16(b[15:0]), 6'd16);
    wire logic [32:0] h_hi = sclamp(sub_sel
        ? sx16(a[31:16]) - sx16(b[31:16])
        : sx16(a[31:16]) + sx16(b[31:16]), 6'd16);

    // Byte lanes
    logic [31:0] byte_res;
    always_comb
    begin
        logic [32:0] t;
        t = 33'h0_0000_0000;
        byte_res = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            t = sclamp(sub_sel ? sx8(a[i*8 +: 8]) - sx8(b[i*8 +: 8])
                               : sx8(a[i*8 +: 8]) + sx8(b[i*8 +: 8]),
                       6'd8);
            byte_res[i*8 +: 8] = t[7:0];
        end
    end

    // Signed exchange forms
    wire logic [32:0] sx_asx_lo =
        sclamp(sx16(a[15:0]) - sx16(b[31:16]), 6'd16);
    wire logic [32:0] sx_asx_hi =
        sclamp(sx16(a[31:16]) + sx16(b[15:0]), 6'd16);
    wire logic [32:0] sx_sax_lo =
        sclamp(sx16(a[15:0]) + sx16(b[31:16]), 6'd16);
    wire logic [32:0] sx_sax_hi =
        sclamp(sx16(a[31:16]) - sx16(b[15:0]), 6'd16);

    // Unsigned exchange forms
    wire logic [32:0] ux_asx_hi =
        uclamp(zx16(a[31:16]) + zx16(b[15:0]), 6'd16);
    wire logic [32:0] ux_asx_lo =
        uclamp(zx16(a[15:0]) - zx16(b[31:16]), 6'd16);
    wire logic [32:0] ux_sax_hi =
        uclamp(zx16(a[31:16]) - zx16(b[15:0]), 6'd16);
    wire logic [32:0] ux_sax_lo =
        uclamp(zx16(a[15:0]) + zx16(b[31:16]), 6'd16);

    // Double-and-add/sub
    wire logic [32:0] dbl = sclamp(b_w + b_w, 6'd32);
    wire logic signed [33:0] dbl_w = 34'(signed'(dbl[31:0]));
    wire logic [32:0] dadd = sclamp(a_w + dbl_w, 6'd32);
    wire logic [32:0] dsub = sclamp(a_w - dbl_w, 6'd32);

    // ------------------------------------------------------------
    // Result and flag selection
    // ------------------------------------------------------------
    logic [31:0] res_sel;
    logic        sat_sel;
    logic        legal;
    always_comb
    begin
        res_sel = 32'h0000_0000;
        sat_sel = 1'b0;
        legal   = 1'b1;
        unique case (op)
            sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP:
            begin
                res_sel = {sc_hi[15:0], sc_lo[15:0]};
                sat_sel = sc_hi[32] | sc_lo[32];
                legal   = pos_ok_s;
            end
            sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP:
            begin
                res_sel = {uc_hi[15:0], uc_lo[15:0]};
                sat_sel = uc_hi[32] | uc_lo[32];
                legal   = pos_ok_u;
            end
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_WORD,
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_WORD:
            begin
                res_sel = w_sum[31:0];
                sat_sel = w_sum[32];
            end
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_HALVES,
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_HALVES:
                res_sel = {h_hi[15:0], h_lo[15:0]};
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_BYTES,
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_BYTES:
                res_sel = byte_res;
            sau_pkg::SAU_OP_SIGNED_ADD_SUB_EXCHANGE:
                res_sel = {sx_asx_hi[15:0], sx_asx_lo[15:0]};
            sau_pkg::SAU_OP_SIGNED_SUB_ADD_EXCHANGE:
                res_sel = {sx_sax_hi[15:0], sx_sax_lo[15:0]};
            sau_pkg::SAU_OP_SAT_DOUBLE_AND_ADD:
            begin
                res_sel = dadd[31:0];
                sat_sel = dbl[32] | dadd[32];
            end
            sau_pkg::SAU_OP_SAT_DOUBLE_AND_SUB:
            begin
                res_sel = dsub[31:0];
                sat_sel = dbl[32] | dsub[32];
            end
            sau_pkg::SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE:
                res_sel = {ux_asx_hi[15:0], ux_asx_lo[15:0]};
            sau_pkg::SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE:
                res_sel = {ux_sax_hi[15:0], ux_sax_lo[15:0]};
            default:
                legal = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Condition gate and registers
    // ------------------------------------------------------------
    logic cond_pass;
    sau_cond_check u_cond
    (
        .cond (cond),
        .nzcv (nzcv_in),
        .pass (cond_pass)
    );

    wire logic exec = op_valid && cond_pass && legal;
    wire logic q_set = exec && sat_sel;

    logic [31:0] result_nxt;
    logic        q_nxt;
    assign result_nxt = exec ? res_sel : result;
    // Set wins over a simultaneous clear
    assign q_nxt = q_set ? 1'b1
                 : (move_to_status_reg ? q_wdata : q_flag);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result       <= sau_pkg::SAU_RESULT_RESET;
            result_valid <= 1'b0;
            q_flag       <= sau_pkg::SAU_Q_RESET;
            sat_event    <= 1'b0;
        end
        else
        begin
            result       <= result_nxt;
            result_valid <= exec;
            q_flag       <= q_nxt;
            sat_event    <= q_set;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_q_sticky_hold: assert property (@(posedge clk) disable iff (!nrst)
        $past(q_flag) && !$past(move_to_status_reg) |-> q_flag)
        else $error("sticky flag dropped without status write");
    a_q_set_word: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && cond_pass && w_sum[32] &&
        (op == sau_pkg::SAU_OP_SIGNED_SAT_ADD_WORD) |=> q_flag)
        else $error("word clamp did not set sticky flag");
    a_q_lane_quiet: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !move_to_status_reg &&
        (op == sau_pkg::SAU_OP_SIGNED_SAT_ADD_BYTES ||
         op == sau_pkg::SAU_OP_SIGNED_SAT_SUB_HALVES)
        |=> q_flag == $past(q_flag))
        else $error("lane add/sub changed sticky flag");
    a_cond_gate: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !cond_pass |=> !result_valid
        && $stable(result))
        else $error("failed condition still wrote result");
    a_exch_result: assert property (@(posedge clk) disable iff (!nrst)
        exec && op == sau_pkg::SAU_OP_SIGNED_ADD_SUB_EXCHANGE
        && !sx_asx_hi[32] && !sx_asx_lo[32] |=> result ==
        {$past(a[31:16] + b[15:0]), $past(a[15:0] - b[31:16])})
        else $error("exchange result mismatch");
    a_dual_set: assert property (@(posedge clk) disable iff (!nrst)
        exec && op == sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP
        && (uc_hi[32] || uc_lo[32]) |=> q_flag && sat_event)
        else $error("dual clamp did not set sticky flag");
    a_pos_range: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && op == sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP
        && sat_pos == 5'h00 |=> !result_valid)
        else $error("illegal clamp position accepted");
    a_dbl_sat: assert property (@(posedge clk) disable iff (!nrst)
        exec && op == sau_pkg::SAU_OP_SAT_DOUBLE_AND_SUB && dbl[32]
        |=> q_flag ##1 q_flag || $past(move_to_status_reg))
        else $error("doubling clamp not flagged");
    c_word_sat: cover property (@(posedge clk) q_set ##1 sat_event);
    c_clear: cover property (@(posedge clk)
        q_flag && move_to_status_reg && !q_wdata ##1 !q_flag);
    c_cond_skip: cover property (@(posedge clk) op_valid && !cond_pass);
endmodule
`default_nettype wire

// ### testbench/sau_decoder_model.sv
/*
 * Decoder and register-file stand-in that issues operations to the
 * saturating unit and writes the sticky flag.
 * Assumes one caller process and a free-running core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sau_decoder_model
(
    input  wire logic        clk,      // Core clock
    output sau_pkg::sau_op_t op,       // Operation
    output logic             op_valid, // Issue strobe
    output logic [3:0]       cond,     // Condition field
    output logic [3:0]       nzcv,     // Condition flags
    output logic [4:0]       sat_pos,  // Clamp position
    output logic [31:0]      a,        // First operand
    output logic [31:0]      b,        // Second operand
    output logic             q_wr,     // Status write strobe
    output logic             q_wdata   // Status write value
);
    initial
    begin
        op = sau_pkg::SAU_OP_NONE;
        op_valid = 1'b0;
        cond = 4'hE;
        nzcv = 4'h0;
        sat_pos = 5'h00;
        a = 32'h0000_0000;
        b = 32'h0000_0000;
        q_wr = 1'b0;
        q_wdata = 1'b0;
    end

    // Operand values stand for general registers only, never SP or PC
    task automatic issue(input sau_pkg::sau_op_t o, input logic [3:0] c,
                         input logic [3:0] f, input logic [4:0] n,
                         input logic [31:0] x, input logic [31:0] y);
        @(negedge clk);
        op_valid <= 1'b1;
        op       <= o;
        cond     <= c;
        nzcv     <= f;
        sat_pos  <= n;
        a        <= x;
        b        <= y;
    endtask

    // Operands scrambled while nothing is issued
    task automatic idle;
        @(negedge clk);
        op_valid <= 1'b0;
        a        <= ~a;
        b        <= ~b;
    endtask

    task automatic write_q(input logic v);
        @(negedge clk);
        op_valid <= 1'b0;
        q_wr     <= 1'b1;
        q_wdata  <= v;
        @(negedge clk);
        q_wr     <= 1'b0;
        q_wdata  <= ~v;
    endtask
endmodule
`default_nettype wire

// ### testbench/sau_core_bench.sv
/*
 * Self-checking bench of the saturating unit: a reference model
 * queues expectations, a monitor compares each result as it appears.
 * Assumes the decoder model in the same folder.
 */
`timescale 1ns/1ps
`default_nettype none
module sau_core_bench;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             op_valid, q_wr, q_wdata, result_valid, q_flag;
    logic             sat_event;
    sau_pkg::sau_op_t op;
    logic [3:0]       cond, nzcv;
    logic [4:0]       sat_pos;
    logic [31:0]      a, b, result, last_r;
    logic [33:0]      exq[$];
    logic             qm = 1'b0;
    int               failures = 0;
    int               num_checks = 0;
    int               cycles = 0;

    always #20 clk = ~clk;

    sau_decoder_model u_dec (.clk(clk), .op(op), .op_valid(op_valid),
        .cond(cond), .nzcv(nzcv), .sat_pos(sat_pos), .a(a), .b(b),
        .q_wr(q_wr), .q_wdata(q_wdata));

    sau_core DUT (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op(op),
        .cond(cond), .nzcv_in(nzcv), .sat_pos(sat_pos),
        .first_operand_register(a), .second_operand_register(b),
        .move_to_status_reg(q_wr), .q_wdata(q_wdata),
        .result_valid(result_valid), .result(result), .q_flag(q_flag),
        .sat_event(sat_event));

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic longint ss(longint v, int n, inout logic s);
        longint hi;
        hi = (longint'(1) << (n - 1)) - 1;
        s = s | (v > hi) | (v < -hi - 1);
        return (v > hi) ? hi : ((v < -hi - 1) ? -hi - 1 : v);
    endfunction

    function automatic longint us(longint v, int n, inout logic s);
        longint hi;
        hi = (longint'(1) << n) - 1;
        s = s | (v > hi) | (v < 0);
        return (v > hi) ? hi : ((v < 0) ? 0 : v);
    endfunction

    function automatic longint ul(logic [31:0] x, int w, int i);
        return (longint'(x) >> (w * i)) & ((longint'(1) << w) - 1);
    endfunction

    function automatic longint sl(logic [31:0] x, int w, int i);
        longint t;
        t = ul(x, w, i);
        return (t >= (longint'(1) << (w - 1))) ? t - (longint'(1) << w) : t;
    endfunction

    function automatic logic [32:0] calc(sau_pkg::sau_op_t o,
                                         logic [31:0] x, logic [31:0] y,
                                         int n);
        logic [31:0] r;
        logic        s;
        logic        d;
        longint      t;
        r = 32'h0;
        s = 1'b0;
        d = 1'b0;
        t = 0;
        case (o)
            sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP:
                for (int i = 0; i < 2; i++)
                    r[16*i+:16] = 16'(ss(sl(y, 16, i), n, s));
            sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP:
                for (int i = 0; i < 2; i++)
                    r[16*i+:16] = 16'(us(sl(y, 16, i), n, s));
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_WORD:
                r = 32'(ss(sl(x, 32, 0) + sl(y, 32, 0), 32, s));
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_WORD:
                r = 32'(ss(sl(x, 32, 0) - sl(y, 32, 0), 32, s));
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_HALVES:
                for (int i = 0; i < 2; i++)
                    r[16*i+:16] = 16'(ss(sl(x, 16, i) + sl(y, 16, i), 16, d));
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_HALVES:
                for (int i = 0; i < 2; i++)
                    r[16*i+:16] = 16'(ss(sl(x, 16, i) - sl(y, 16, i), 16, d));
            sau_pkg::SAU_OP_SIGNED_SAT_ADD_BYTES:
                for (int i = 0; i < 4; i++)
                    r[8*i+:8] = 8'(ss(sl(x, 8, i) + sl(y, 8, i), 8, d));
            sau_pkg::SAU_OP_SIGNED_SAT_SUB_BYTES:
                for (int i = 0; i < 4; i++)
                    r[8*i+:8] = 8'(ss(sl(x, 8, i) - sl(y, 8, i), 8, d));
            sau_pkg::SAU_OP_SIGNED_ADD_SUB_EXCHANGE:
            begin
                r[31:16] = 16'(ss(sl(x, 16, 1) + sl(y, 16, 0), 16, d));
                r[15:0] = 16'(ss(sl(x, 16, 0) - sl(y, 16, 1), 16, d));
            end
            sau_pkg::SAU_OP_SIGNED_SUB_ADD_EXCHANGE:
            begin
                r[31:16] = 16'(ss(sl(x, 16, 1) - sl(y, 16, 0), 16, d));
                r[15:0] = 16'(ss(sl(x, 16, 0) + sl(y, 16, 1), 16, d));
            end
            sau_pkg::SAU_OP_SAT_DOUBLE_AND_ADD:
            begin
                t = ss(2 * sl(y, 32, 0), 32, s);
                r = 32'(ss(sl(x, 32, 0) + t, 32, s));
            end
            sau_pkg::SAU_OP_SAT_DOUBLE_AND_SUB:
            begin
                t = ss(2 * sl(y, 32, 0), 32, s);
                r = 32'(ss(sl(x, 32, 0) - t, 32, s));
            end
            sau_pkg::SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE:
            begin
                r[31:16] = 16'(us(ul(x, 16, 1) + ul(y, 16, 0), 16, d));
                r[15:0] = 16'(us(ul(x, 16, 0) - ul(y, 16, 1), 16, d));
            end
            sau_pkg::SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE:
            begin
                r[31:16] = 16'(us(ul(x, 16, 1) - ul(y, 16, 0), 16, d));
                r[15:0] = 16'(us(ul(x, 16, 0) + ul(y, 16, 1), 16, d));
            end
            default:
                r = 32'h0;
        endcase
        return {s, r};
    endfunction

    function automatic logic cpass(logic [3:0] c, logic [3:0] f);
        case (c)
            4'h0: return f[2];
            4'h1: return !f[2];
            4'h2: return f[1];
            4'h3: return !f[1];
            4'h4: return f[3];
            4'h5: return !f[3];
            4'h6: return f[0];
            4'h7: return !f[0];
            4'h8: return f[1] && !f[2];
            4'h9: return !f[1] || f[2];
            4'hA: return f[3] == f[0];
            4'hB: return f[3] != f[0];
            4'hC: return !f[2] && (f[3] == f[0]);
            4'hD: return f[2] || (f[3] != f[0]);
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] rv;
        case ($urandom % 8)
            0: return 32'h7FFF_FFFF;
            1: return 32'h8000_0000;
            2: return 32'h8000_7FFF;
            3: return 32'h7F80_807F;
            default: return $urandom;
        endcase
    endfunction

    task automatic go(sau_pkg::sau_op_t o, logic [3:0] c, logic [3:0] f,
                      logic [4:0] n, logic [31:0] x, logic [31:0] y);
        logic [32:0] e;
        logic        ok;
        e = calc(o, x, y, n);
        ok = cpass(c, f) && o != sau_pkg::SAU_OP_NONE;
        if (o == sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP)
            ok = ok && n >= 1 && n <= 16;
        if (o == sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP)
            ok = ok && n <= 15;
        if (ok)
        begin
            qm = qm | e[32];
            last_r = e[31:0];
            exq.push_back({e[32], qm, e[31:0]});
        end
        u_dec.issue(o, c, f, n, x, y);
    endtask

    // ------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------
    always @(negedge clk)
        if (nrst && result_valid === 1'b1)
        begin
            if (exq.size() == 0)
                chk("unexpected result", 32'h0, 32'h1);
            else
            begin
                chk("result", exq[0][31:0], result);
                chk("q_flag", exq[0][32], q_flag);
                chk("sat_event", exq[0][33], sat_event);
                void'(exq.pop_front());
            end
        end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            failures++;
            $display("Error timeout expected end seen none");
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hA131858F));
        last_r = 32'h0;
        repeat (6) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        chk("reset result", 32'h0, result);
        chk("reset q_flag", 32'h0, q_flag);
        $display("test reset done");
        go(sau_pkg::SAU_OP_SIGNED_SAT_ADD_WORD, 4'hE, 4'h0, 5'h00,
           32'h7FFF_FFFF, 32'h0000_0001);
        u_dec.write_q(1'b0);
        qm = 1'b0;
        @(negedge clk);
        chk("q after clear", 32'h0, q_flag);
        u_dec.write_q(1'b1);
        @(negedge clk);
        chk("q after write", 32'h1, q_flag);
        $display("test flag write done");
        for (int i = 0; i < 15; i++)
        begin
            for (int k = 0; k < 48; k++)
            begin
                if (k % 8 == 0)
                begin
                    u_dec.write_q(1'b0);
                    qm = 1'b0;
                end
                go(sau_pkg::sau_op_t'(i), ($urandom % 2) ? 4'hE : 4'($urandom),
                   4'($urandom), 5'($urandom % 18), rv(), rv());
            end
            go(sau_pkg::sau_op_t'(i), 4'h0, 4'h0, 5'h08,
               32'h7FFF_FFFF, 32'h8000_7FFF);
            u_dec.idle();
            repeat (2) @(negedge clk);
            chk("held result", last_r, result);
            chk("queue empty", 32'h0, 32'(exq.size()));
            $display("test op %0d done", i);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
